// ==== hw/mqf_pkg.sv ====
// constants shared by the multi-queue fifo design
package mqf_pkg;
	// queue and memory geometry
	localparam int NUM_Q = 32;
	localparam int QSEL_W = 5;
	localparam int WORD_W = 36;
	localparam int BLK_WORDS = 256;
	localparam int BLK_SHIFT = 8;
	localparam int NBLK_SMALL = 128;
	localparam int NBLK_LARGE = 256;
	// flag busses
	localparam int FLAG_W = 8;
	localparam int QUAD_W = 2;
	// packet markers
	localparam int SOP_BIT = 34;
	localparam int EOP_BIT = 35;
	// register map
	localparam int REG_AW = 10;
	localparam logic [9:0] CTRL_OFS = 10'h000;
	localparam logic [9:0] PKT_OFS = 10'h004;
	localparam logic [9:0] NEMPTY_OFS = 10'h008;
	localparam logic [9:0] DEPTH_BASE = 10'h100;
	localparam logic [9:0] AF_BASE = 10'h200;
	localparam logic [9:0] AE_BASE = 10'h300;
	localparam int IDX_LSB = 2;
	localparam int TBL_LSB = 8;
	// control register fields
	localparam int CTRL_NQ_LSB = 0;
	localparam int CTRL_NQ_W = 6;
	localparam int CTRL_POLL_BIT = 6;
	localparam int CTRL_PKT_BIT = 7;
	// reset values
	localparam logic [5:0] DEF_NQ = 6'h20;
	localparam int DEF_THR = 8;
	// strap capture point after reset release
	localparam logic [1:0] STRAP_CNT = 2'h2;
endpackage : mqf_pkg

// ==== hw/mqf_mem_if.sv ====
// storage port between the queue controller and the word memory
`timescale 1ns/100ps
interface mqf_mem_if #(
	parameter int AW = 15,
	parameter int DW = 36
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mqf_mem_if

// ==== hw/mqf_mem.sv ====
// shared word memory built from flip-flops
`timescale 1ns/100ps
module mqf_mem #(
	parameter int AW = 15,
	parameter int DW = 36,
	parameter int DEPTH = 32768
) (
	// clock
	input wire logic core_clk_i,
	// storage port
	mqf_mem_if.mem bus
);
	logic [DW-1:0] mem_r [DEPTH];

	always_ff @(posedge core_clk_i) begin
		if (bus.we) begin
			mem_r[bus.waddr] <= bus.wdata;
		end
	end

	assign bus.rdata = mem_r[bus.raddr];
endmodule : mqf_mem

// ==== hw/mqf_top.sv ====
// multi-queue fifo: queue pointers, flags, bus matching, flag busses, config registers
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module mqf_top #(
	parameter int IN_W = mqf_pkg::WORD_W,
	parameter int OUT_W = mqf_pkg::WORD_W,
	parameter int NBLK = mqf_pkg::NBLK_SMALL
) (
	// clock and master reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// setup straps and partial reset
	input wire logic polled_sel_i,
	input wire logic packet_sel_i,
	input wire logic part_rst_i,
	// write port
	input wire logic [mqf_pkg::QSEL_W-1:0] wr_q_i,
	input wire logic wr_en_i,
	input wire logic [IN_W-1:0] wr_data_i,
	output logic write_queue_full_o,
	output logic almost_full_flag_o,
	// read port
	input wire logic [mqf_pkg::QSEL_W-1:0] rd_q_i,
	input wire logic rd_en_i,
	output logic [OUT_W-1:0] rd_data_o,
	output logic read_valid_flag_o,
	output logic almost_empty_flag_o,
	output logic packet_ready_flag_o,
	// flag status busses
	input wire logic [mqf_pkg::QUAD_W-1:0] af_quad_i,
	input wire logic [mqf_pkg::QUAD_W-1:0] ae_quad_i,
	output logic [mqf_pkg::FLAG_W-1:0] af_bus_o,
	output logic [mqf_pkg::QUAD_W-1:0] af_bus_quad_o,
	output logic [mqf_pkg::FLAG_W-1:0] ae_bus_o,
	output logic [mqf_pkg::QUAD_W-1:0] ae_bus_quad_o,
	// register port
	input wire logic [mqf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	localparam int NQ = mqf_pkg::NUM_Q;
	localparam int QW = mqf_pkg::QSEL_W;
	localparam int WW = mqf_pkg::WORD_W;
	localparam int MW = NBLK * mqf_pkg::BLK_WORDS;
	localparam int AW = $clog2(MW);
	localparam int CW = AW + 1;
	localparam int DBW = $clog2(NBLK + 1);
	localparam int IR = WW / IN_W;
	localparam int OR = WW / OUT_W;
	localparam logic PKT_OK = (IN_W == WW) && (OUT_W == WW);

	// configuration state
	logic [5:0] nq_r, nq_nxt;
	logic poll_r, poll_nxt;
	logic pkt_r, pkt_nxt;
	logic [1:0] init_r, init_nxt;
	logic [1:0] strap_s1_r, strap_s2_r;
	logic [DBW-1:0] depth_r [NQ];
	logic [DBW-1:0] depth_nxt [NQ];
	logic [CW-1:0] af_thr_r [NQ];
	logic [CW-1:0] af_thr_nxt [NQ];
	logic [CW-1:0] ae_thr_r [NQ];
	logic [CW-1:0] ae_thr_nxt [NQ];
	logic [31:0] rdata_r, rdata_nxt;
	logic [QW-1:0] ridx;
	logic [NQ-1:0] pr_vec, ne_vec;

	// queue state
	logic [AW-1:0] wptr_r [NQ];
	logic [AW-1:0] wptr_nxt [NQ];
	logic [AW-1:0] rptr_r [NQ];
	logic [AW-1:0] rptr_nxt [NQ];
	logic [CW-1:0] cnt_r [NQ];
	logic [CW-1:0] cnt_nxt [NQ];
	logic [CW-1:0] eop_r [NQ];
	logic [CW-1:0] eop_nxt [NQ];
	logic [WW-1:0] pack_r, pack_nxt, word;
	logic [1:0] pcnt_r, pcnt_nxt;
	logic [WW-1:0] out_r, out_nxt;
	logic [OUT_W-1:0] rd_data_nxt;
	logic [1:0] rs_r, rs_nxt;
	logic valid_r, valid_nxt;
	logic [QW-1:0] rq_prev_r;
	logic prst, wr_ok, commit, same_q, rd_take, pop, pkt_act;
	logic [AW-1:0] waddr, raddr;

	// flag bus state
	logic [mqf_pkg::QUAD_W-1:0] poll_q_r, poll_q_nxt, afq, aeq;
	logic [mqf_pkg::FLAG_W-1:0] af_bus_nxt, ae_bus_nxt;

	mqf_mem_if #(.AW(AW), .DW(WW)) mem_bus ();

	mqf_mem #(.AW(AW), .DW(WW), .DEPTH(MW)) u_mem (
		.core_clk_i(core_clk_i),
		.bus(mem_bus.mem)
	);

	function automatic logic [CW-1:0] qwords(input logic [DBW-1:0] d);
		return CW'(d) << mqf_pkg::BLK_SHIFT;
	endfunction : qwords

	function automatic logic qactive(input logic [QW-1:0] q);
		return {1'b0, q} < nq_r;
	endfunction : qactive

	// queues occupy consecutive block runs in queue order
	function automatic logic [AW-1:0] qbase(input logic [QW-1:0] q);
		logic [CW-1:0] s;
		s = '0;
		for (int i = 0; i < NQ; i++) begin
			if (i < int'(q)) begin
				s = s + qwords(depth_r[i]);
			end
		end
		return s[AW-1:0];
	endfunction : qbase

	function automatic logic [AW-1:0] pinc(input logic [AW-1:0] p, input logic [QW-1:0] q);
		logic [CW-1:0] n;
		n = CW'(p) + CW'(1);
		return (n == qwords(depth_r[q])) ? '0 : n[AW-1:0];
	endfunction : pinc

	function automatic logic qfull(input logic [QW-1:0] q);
		return !qactive(q) || (cnt_r[q] >= qwords(depth_r[q]));
	endfunction : qfull

	function automatic logic qaf(input logic [QW-1:0] q);
		return qactive(q) && ({1'b0, cnt_r[q]} + {1'b0, af_thr_r[q]} >= {1'b0, qwords(depth_r[q])});
	endfunction : qaf

	function automatic logic qae(input logic [QW-1:0] q);
		return qactive(q) && (cnt_r[q] <= ae_thr_r[q]);
	endfunction : qae

	// ---- queue datapath ----
	always_comb begin
		pkt_act = pkt_r && PKT_OK;
		prst = part_rst_i && (wr_q_i == rd_q_i);
		wr_ok = wr_en_i && !qfull(wr_q_i);
		word = pack_r;
		word[int'(pcnt_r) * IN_W +: IN_W] = wr_data_i;
		commit = wr_ok && (pcnt_r == 2'(IR - 1));
		pcnt_nxt = pcnt_r;
		pack_nxt = pack_r;
		if (wr_ok) begin
			pack_nxt = word;
			pcnt_nxt = commit ? 2'h0 : pcnt_r + 2'h1;
		end
		if (prst) begin
			pcnt_nxt = 2'h0;
		end
		waddr = qbase(wr_q_i) + wptr_r[wr_q_i];
		same_q = (rd_q_i == rq_prev_r);
		rd_take = rd_en_i && valid_r && same_q;
		pop = rd_take && (rs_r == 2'(OR - 1));
		for (int q = 0; q < NQ; q++) begin
			wptr_nxt[q] = wptr_r[q];
			rptr_nxt[q] = rptr_r[q];
			cnt_nxt[q] = cnt_r[q];
			eop_nxt[q] = eop_r[q];
			if (commit && (int'(wr_q_i) == q)) begin
				wptr_nxt[q] = pinc(wptr_r[q], QW'(q));
				cnt_nxt[q] = cnt_nxt[q] + CW'(1);
				eop_nxt[q] = eop_nxt[q] + CW'(word[mqf_pkg::EOP_BIT]);
			end
			if (pop && (int'(rd_q_i) == q)) begin
				rptr_nxt[q] = pinc(rptr_r[q], QW'(q));
				cnt_nxt[q] = cnt_nxt[q] - CW'(1);
				eop_nxt[q] = eop_nxt[q] - CW'(out_r[mqf_pkg::EOP_BIT]);
			end
			if (prst && (int'(wr_q_i) == q)) begin
				wptr_nxt[q] = '0;
				rptr_nxt[q] = '0;
				cnt_nxt[q] = '0;
				eop_nxt[q] = '0;
			end
		end
		raddr = qbase(rd_q_i) + rptr_nxt[rd_q_i];
		out_nxt = out_r;
		valid_nxt = 1'b0;
		if (cnt_nxt[rd_q_i] != '0) begin
			out_nxt = (commit && (waddr == raddr)) ? word : mem_bus.rdata;
			valid_nxt = 1'b1;
		end
		rs_nxt = rs_r;
		if (!same_q || prst) begin
			rs_nxt = 2'h0;
		end else if (rd_take) begin
			rs_nxt = pop ? 2'h0 : rs_r + 2'h1;
		end
		rd_data_nxt = out_nxt[int'(rs_nxt) * OUT_W +: OUT_W];
	end

	assign mem_bus.we = commit;
	assign mem_bus.waddr = waddr;
	assign mem_bus.wdata = word;
	assign mem_bus.raddr = raddr;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int q = 0; q < NQ; q++) begin
				wptr_r[q] <= '0;
				rptr_r[q] <= '0;
				cnt_r[q] <= '0;
				eop_r[q] <= '0;
			end
			pack_r <= '0;
			pcnt_r <= 2'h0;
			out_r <= '0;
			rd_data_o <= '0;
			rs_r <= 2'h0;
			valid_r <= 1'b0;
			rq_prev_r <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			eop_r <= eop_nxt;
			pack_r <= pack_nxt;
			pcnt_r <= pcnt_nxt;
			out_r <= out_nxt;
			rd_data_o <= rd_data_nxt;
			rs_r <= rs_nxt;
			valid_r <= valid_nxt;
			rq_prev_r <= rd_q_i;
		end
	end

	// selected-queue flags
	assign write_queue_full_o = qfull(wr_q_i);
	assign almost_full_flag_o = qaf(wr_q_i);
	assign read_valid_flag_o = valid_r && same_q;
	assign almost_empty_flag_o = qae(rd_q_i);
	assign packet_ready_flag_o = pkt_act && (eop_r[rd_q_i] != '0);

	// ---- flag status busses ----
	always_comb begin
		poll_q_nxt = poll_q_r + 2'h1;
		afq = poll_r ? poll_q_r : af_quad_i;
		aeq = poll_r ? poll_q_r : ae_quad_i;
		if (nq_r <= 6'(mqf_pkg::FLAG_W)) begin
			afq = '0;
			aeq = '0;
		end
		for (int i = 0; i < mqf_pkg::FLAG_W; i++) begin
			af_bus_nxt[i] = qaf({afq, 3'(i)});
			ae_bus_nxt[i] = pkt_act ? (qactive({aeq, 3'(i)}) && eop_r[{aeq, 3'(i)}] != '0) : qae({aeq, 3'(i)});
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			poll_q_r <= '0;
			af_bus_o <= '0;
			ae_bus_o <= '0;
			af_bus_quad_o <= '0;
			ae_bus_quad_o <= '0;
		end else begin
			poll_q_r <= poll_q_nxt;
			af_bus_o <= af_bus_nxt;
			ae_bus_o <= ae_bus_nxt;
			af_bus_quad_o <= afq;
			ae_bus_quad_o <= aeq;
		end
	end

	// ---- configuration registers ----
	always_comb begin
		ridx = reg_addr_i[mqf_pkg::IDX_LSB +: QW];
		for (int q = 0; q < NQ; q++) begin
			pr_vec[q] = pkt_act && (eop_r[q] != '0);
			ne_vec[q] = (cnt_r[q] != '0);
		end
		nq_nxt = nq_r;
		poll_nxt = poll_r;
		pkt_nxt = pkt_r;
		init_nxt = init_r;
		depth_nxt = depth_r;
		af_thr_nxt = af_thr_r;
		ae_thr_nxt = ae_thr_r;
		if (init_r != mqf_pkg::STRAP_CNT) begin
			init_nxt = init_r + 2'h1;
			if (init_r + 2'h1 == mqf_pkg::STRAP_CNT) begin
				poll_nxt = strap_s2_r[0];
				pkt_nxt = strap_s2_r[1];
			end
		end else if (reg_wr_i) begin
			unique case (reg_addr_i[mqf_pkg::REG_AW-1:mqf_pkg::TBL_LSB])
				mqf_pkg::CTRL_OFS[9:8]: begin
					if (reg_addr_i == mqf_pkg::CTRL_OFS) begin
						nq_nxt = reg_wdata_i[mqf_pkg::CTRL_NQ_LSB +: mqf_pkg::CTRL_NQ_W];
						poll_nxt = reg_wdata_i[mqf_pkg::CTRL_POLL_BIT];
						pkt_nxt = reg_wdata_i[mqf_pkg::CTRL_PKT_BIT];
					end
				end
				mqf_pkg::DEPTH_BASE[9:8]: depth_nxt[ridx] = reg_wdata_i[DBW-1:0];
				mqf_pkg::AF_BASE[9:8]: af_thr_nxt[ridx] = reg_wdata_i[CW-1:0];
				mqf_pkg::AE_BASE[9:8]: ae_thr_nxt[ridx] = reg_wdata_i[CW-1:0];
			endcase
		end
		rdata_nxt = '0;
		if (reg_rd_i) begin
			unique case (reg_addr_i[mqf_pkg::REG_AW-1:mqf_pkg::TBL_LSB])
				mqf_pkg::CTRL_OFS[9:8]: begin
					if (reg_addr_i == mqf_pkg::CTRL_OFS) begin
						rdata_nxt[mqf_pkg::CTRL_NQ_LSB +: mqf_pkg::CTRL_NQ_W] = nq_r;
						rdata_nxt[mqf_pkg::CTRL_POLL_BIT] = poll_r;
						rdata_nxt[mqf_pkg::CTRL_PKT_BIT] = pkt_r;
					end else if (reg_addr_i == mqf_pkg::PKT_OFS) begin
						rdata_nxt = pr_vec;
					end else if (reg_addr_i == mqf_pkg::NEMPTY_OFS) begin
						rdata_nxt = ne_vec;
					end
				end
				mqf_pkg::DEPTH_BASE[9:8]: rdata_nxt[DBW-1:0] = depth_r[ridx];
				mqf_pkg::AF_BASE[9:8]: rdata_nxt[CW-1:0] = af_thr_r[ridx];
				mqf_pkg::AE_BASE[9:8]: rdata_nxt[CW-1:0] = ae_thr_r[ridx];
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nq_r <= mqf_pkg::DEF_NQ;
			poll_r <= 1'b0;
			pkt_r <= 1'b0;
			init_r <= 2'h0;
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
			for (int q = 0; q < NQ; q++) begin
				depth_r[q] <= DBW'(NBLK / NQ);
				af_thr_r[q] <= CW'(mqf_pkg::DEF_THR);
				ae_thr_r[q] <= CW'(mqf_pkg::DEF_THR);
			end
			rdata_r <= '0;
		end else begin
			nq_r <= nq_nxt;
			poll_r <= poll_nxt;
			pkt_r <= pkt_nxt;
			init_r <= init_nxt;
			strap_s1_r <= {packet_sel_i, polled_sel_i};
			strap_s2_r <= strap_s1_r;
			depth_r <= depth_nxt;
			af_thr_r <= af_thr_nxt;
			ae_thr_r <= ae_thr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
endmodule : mqf_top

// ==== verif/mqf_top_assertions.sv ====
// concurrent checks on the multi-queue fifo top ports
`timescale 1ns/100ps
module mqf_top_assertions #(
	parameter int OUT_W = 36
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// data ports
	input wire logic part_rst_i,
	input wire logic [mqf_pkg::QSEL_W-1:0] wr_q_i,
	input wire logic wr_en_i,
	input wire logic write_queue_full_o,
	input wire logic [mqf_pkg::QSEL_W-1:0] rd_q_i,
	input wire logic rd_en_i,
	input wire logic [OUT_W-1:0] rd_data_o,
	input wire logic read_valid_flag_o,
	input wire logic almost_empty_flag_o,
	// flag busses and registers
	input wire logic [mqf_pkg::QUAD_W-1:0] af_quad_i,
	input wire logic [mqf_pkg::QUAD_W-1:0] af_bus_quad_o,
	input wire logic [mqf_pkg::QUAD_W-1:0] ae_bus_quad_o,
	input wire logic [mqf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o
);
	// polled mode as last written by software
	logic poll_r;
	logic poll_nxt;
	always_comb begin
		poll_nxt = poll_r;
		if (reg_wr_i && reg_addr_i == mqf_pkg::CTRL_OFS)
			poll_nxt = reg_wdata_i[mqf_pkg::CTRL_POLL_BIT];
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			poll_r <= 1'b0;
		else
			poll_r <= poll_nxt;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	a_valid_select: assert property ($changed(rd_q_i) |-> !read_valid_flag_o)
		else $error("valid shown on a fresh selection");
	a_fall_through: assert property (wr_en_i && !write_queue_full_o && wr_q_i == rd_q_i && !read_valid_flag_o
		&& !part_rst_i ##1 $stable(rd_q_i) |-> read_valid_flag_o) else $error("written word did not fall through");
	a_empty_hold: assert property ($changed(rd_data_o) && $stable(rd_q_i) |-> read_valid_flag_o)
		else $error("output word changed without valid");
	a_full_refuse: assert property (wr_en_i && write_queue_full_o && !part_rst_i && !(rd_en_i && rd_q_i == wr_q_i)
		##1 $stable(wr_q_i) |-> write_queue_full_o) else $error("write into full queue changed it");
	a_part_clear: assert property (part_rst_i && wr_q_i == rd_q_i && !wr_en_i ##1 $stable(rd_q_i)
		|-> almost_empty_flag_o) else $error("partial reset left data");
	a_quad_direct: assert property ($past(nrst_i) && !$past(poll_r) |-> af_bus_quad_o == $past(af_quad_i))
		else $error("direct quadrant not followed");
	a_quad_polled: assert property ($past(poll_r) && $past(poll_r, 2) |->
		af_bus_quad_o == $past(af_bus_quad_o) + 2'h1 && ae_bus_quad_o == $past(ae_bus_quad_o) + 2'h1)
		else $error("polled quadrant did not step");
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_ctrl_read: assert property ($past(reg_rd_i) && $past(reg_addr_i) == mqf_pkg::CTRL_OFS |->
		reg_rdata_o[mqf_pkg::CTRL_POLL_BIT] == $past(poll_r)) else $error("mode bit read back wrong");
	c_full_refused: cover property (wr_en_i && write_queue_full_o);
	c_part_rst: cover property (part_rst_i && wr_q_i == rd_q_i);
	c_polled: cover property ($past(poll_r) && af_bus_quad_o == 2'h3);
endmodule : mqf_top_assertions

// ==== verif/mqf_peer.sv ====
// upstream writer and downstream reader beside the fifo
`timescale 1ns/100ps
module mqf_peer (
	// clock
	input wire logic core_clk_i,
	// write side
	input wire logic full_i,
	output logic [mqf_pkg::QSEL_W-1:0] wr_q_o,
	output logic wr_en_o,
	output logic [mqf_pkg::WORD_W-1:0] wr_data_o,
	// read side
	input wire logic valid_i,
	input wire logic [mqf_pkg::WORD_W-1:0] rd_data_i,
	output logic [mqf_pkg::QSEL_W-1:0] rd_q_o,
	output logic rd_en_o
);
	initial begin
		wr_q_o = '0;
		wr_en_o = 1'b0;
		wr_data_o = '0;
		rd_q_o = '0;
		rd_en_o = 1'b0;
	end
	// n words d, d+1.. one per cycle; blind ignores full
	task automatic put(input logic [4:0] q, input logic [35:0] d, input int n, input bit blind);
		for (int i = 0; i < n; i++) begin
			wr_q_o <= q;
			#1;
			if (full_i && !blind)
				break;
			wr_en_o <= 1'b1;
			wr_data_o <= d + 36'(i);
			@(posedge core_clk_i);
			#1;
		end
		wr_en_o <= 1'b0;
		wr_data_o <= ~wr_data_o;
	endtask : put
	// one word, consumed once shown valid or after 40 cycles without valid
	task automatic take(input logic [4:0] q, output logic [35:0] d);
		rd_q_o <= q;
		#1;
		for (int i = 0; i < 40 && valid_i !== 1'b1; i++) begin
			@(posedge core_clk_i);
			#1;
		end
		d = rd_data_i;
		rd_en_o <= 1'b1;
		@(posedge core_clk_i);
		#1;
		rd_en_o <= 1'b0;
	endtask : take
endmodule : mqf_peer

// ==== verif/tb_top.sv ====
// self-checking bench for the multi-queue fifo
`timescale 1ns/100ps
module tb_top;
	logic core_clk_i, nrst_i, part_rst_i, reg_wr, reg_rd, wr_en, rd_en, full, af, valid, ae, pr;
	logic [1:0] quad, af_bq, qs;
	logic [9:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [4:0] wr_q, rd_q;
	logic [35:0] wr_data, rd_data, got;
	logic [7:0] af_bus, ae_bus;
	int n_errors = 0;
	int n_compared = 0;
	typedef struct packed {logic [4:0] q; logic [35:0] d;} mqf_row_t;
	mqf_row_t rows [4] = '{'{5'h00, 36'h1_2345_6789}, '{5'h05, 36'hA_5A5A_5A5A}, '{5'h1F, 36'h8_0000_0001},
		'{5'h05, 36'h5_A5A5_A5A5}};
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	mqf_top u_dut (.core_clk_i, .nrst_i, .polled_sel_i(1'b0), .packet_sel_i(1'b0), .part_rst_i, .wr_q_i(wr_q),
		.wr_en_i(wr_en), .wr_data_i(wr_data), .write_queue_full_o(full), .almost_full_flag_o(af), .rd_q_i(rd_q),
		.rd_en_i(rd_en), .rd_data_o(rd_data), .read_valid_flag_o(valid), .almost_empty_flag_o(ae),
		.packet_ready_flag_o(pr), .af_quad_i(quad), .ae_quad_i(quad), .af_bus_o(af_bus), .af_bus_quad_o(af_bq),
		.ae_bus_o(ae_bus), .ae_bus_quad_o(), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
	mqf_peer u_peer (.core_clk_i, .full_i(full), .wr_q_o(wr_q), .wr_en_o(wr_en), .wr_data_o(wr_data),
		.valid_i(valid), .rd_data_i(rd_data), .rd_q_o(rd_q), .rd_en_o(rd_en));
	task automatic chk_v(input logic [35:0] g, input logic [35:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t value %h expected %h", $time, g, e);
		end
	endtask : chk_v
	task automatic chk_f(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t flag %b expected %b", $time, g, e);
		end
	endtask : chk_f
	task automatic rg_wr(input logic [9:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk_i);
		reg_wr <= 1'b0;
	endtask : rg_wr
	task automatic rg_rd(input logic [9:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk_i);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rg_rd
	task automatic conclude();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		#50000;
		n_errors++;
		conclude();
	end
	initial begin
		nrst_i = 1'b0;
		part_rst_i = 1'b0;
		quad = 2'h0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk_f(full, 1'b0);
		chk_f(ae, 1'b1);
		chk_f(valid, 1'b0);
		rg_rd(mqf_pkg::CTRL_OFS, rv);
		chk_v(36'(rv), 36'h20);
		rg_rd(mqf_pkg::DEPTH_BASE + 10'h00C, rv);
		chk_v(36'(rv), 36'h4);
		rg_rd(10'h0FC, rv);
		chk_v(36'(rv), 36'h0);
		foreach (rows[i]) u_peer.put(rows[i].q, rows[i].d, 1, 1'b0);
		foreach (rows[i]) begin
			u_peer.take(rows[i].q, got);
			chk_v(got, rows[i].d);
		end
		rg_wr(mqf_pkg::DEPTH_BASE + 10'h00C, 32'h1);
		rg_wr(mqf_pkg::AF_BASE + 10'h00C, 32'h10);
		u_peer.put(5'h03, 36'h0, 239, 1'b0);
		chk_f(af, 1'b0);
		u_peer.put(5'h03, 36'd239, 1, 1'b0);
		chk_f(af, 1'b1);
		u_peer.put(5'h03, 36'd240, 16, 1'b0);
		chk_f(full, 1'b1);
		u_peer.put(5'h03, 36'hF_FFFF_FFFF, 1, 1'b1);
		chk_f(af_bus[3], 1'b1);
		@(posedge core_clk_i);
		quad <= 2'h1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk_v(36'(af_bq), 36'h1);
		for (int i = 0; i < 256; i++) begin
			u_peer.take(5'h03, got);
			chk_v(got, 36'(i));
			if (i == 1) chk_f(ae, 1'b0);
		end
		u_peer.rd_q_o <= 5'h09;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk_f(valid, 1'b0);
		chk_v(rd_data, 36'hFF);
		u_peer.put(5'h07, 36'h7, 3, 1'b0);
		u_peer.take(5'h07, got);
		chk_v(got, 36'h7);
		@(posedge core_clk_i);
		part_rst_i <= 1'b1;
		@(posedge core_clk_i);
		part_rst_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chk_f(ae, 1'b1);
		u_peer.put(5'h07, 36'h55, 1, 1'b0);
		u_peer.take(5'h07, got);
		chk_v(got, 36'h55);
		rg_wr(mqf_pkg::CTRL_OFS, 32'h60);
		rg_rd(mqf_pkg::CTRL_OFS, rv);
		chk_v(36'(rv), 36'h60);
		repeat (3) @(posedge core_clk_i);
		#1;
		qs = af_bq + 2'h1;
		@(posedge core_clk_i);
		#1;
		chk_v(36'(af_bq), 36'(qs));
		// packet mode: start marker alone is no packet, end marker completes it
		rg_wr(mqf_pkg::CTRL_OFS, 32'hA0);
		u_peer.rd_q_o <= 5'h0A;
		u_peer.put(5'h0A, 36'h4_0000_0000, 1, 1'b0);
		chk_f(pr, 1'b0);
		u_peer.put(5'h0A, 36'h8_0000_0002, 1, 1'b0);
		chk_f(pr, 1'b1);
		@(posedge core_clk_i);
		#1;
		chk_f(ae_bus[2], 1'b1);
		u_peer.take(5'h0A, got);
		chk_v(got, 36'h4_0000_0000);
		u_peer.take(5'h0A, got);
		chk_v(got, 36'h8_0000_0002);
		chk_f(pr, 1'b0);
		// master reset in mid-run restores defaults
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk_f(pr, 1'b0);
		chk_f(ae, 1'b1);
		chk_f(valid, 1'b0);
		rg_rd(mqf_pkg::CTRL_OFS, rv);
		chk_v(36'(rv), 36'h20);
		conclude();
	end
endmodule : tb_top
bind mqf_top mqf_top_assertions #(.OUT_W(OUT_W)) u_chk (.core_clk_i, .nrst_i, .part_rst_i, .wr_q_i, .wr_en_i,
	.write_queue_full_o, .rd_q_i, .rd_en_i, .rd_data_o, .read_valid_flag_o, .almost_empty_flag_o, .af_quad_i,
	.af_bus_quad_o, .ae_bus_quad_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
